// *** rtl/dtf_consts.vh ***
// Constants for the delay timer functions block
// What this block does
// R01: On delay: rising trigger clears, starts timer
// R02: On delay: output high at expiry, while trigger
// R03: On delay: early trigger drop clears, no output
// R04: On delay: output low whenever trigger low
// R05: Reset clears every elapsed time counter
// R06: Off delay: output follows high trigger immediately
// R07: Off delay: falling edge restarts timer, output high
// R08: Off delay: output low when timer reaches delay
// R09: Off delay: new pulse retriggers on next fall
// R10: Off delay: clear resets timer, forces output low
// R11: On/off: rising edge starts rise delay timer
// R12: On/off: early fall clears, output stays low
// R13: On/off: falling edge starts fall delay timer
// R14: On/off: early rise clears, output stays high
// R15: Retentive: rising edge starts, output at expiry
// R16: Retentive: later trigger changes ignored
// R17: Retentive: only clear or reset returns output and timer
// R18: Counters step per tick, saturate at target
// R19: Clear beats trigger edge in same cycle
`ifndef DTF_CONSTS_VH
`define DTF_CONSTS_VH

// ----------------------------------------
// Widths and modes
// ----------------------------------------
`define DTF_TW        16
`define DTF_ZERO      16'h0000
`define DTF_ONE       16'h0001
`define DTF_MODE_W    2
`define DTF_MODE_ON   2'h0
`define DTF_MODE_OFF  2'h1
`define DTF_MODE_ONOF 2'h2
`define DTF_MODE_RET  2'h3

// ----------------------------------------
// Synchroniser lanes
// ----------------------------------------
`define DTF_PIN_N     2
`define DTF_PIN_TRG   0
`define DTF_PIN_CLR   1

`endif

// *** rtl/dtf_counter.v ***
// Saturating elapsed-time counter stepped by the time-base tick
`timescale 1ns/1ps
`default_nettype none
`include "dtf_consts.vh"

module dtf_counter
(
    input  wire                 mclk,    // System clock
    input  wire                 rst,     // Async reset, high
    input  wire                 clr,     // Restart from zero
    input  wire                 run,     // Counting allowed
    input  wire                 tick,    // Time-base tick
    input  wire [`DTF_TW-1:0]   target,  // Saturation value
    output reg  [`DTF_TW-1:0]   count_q, // Elapsed time
    output wire                 done     // Count reached target
);

    assign done = (count_q >= target);

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            count_q <= `DTF_ZERO;                          // [R05]
        else if (clr)
            count_q <= `DTF_ZERO;
        else if (run && tick && !done)
            count_q <= count_q + `DTF_ONE;                 // [R18]
    end

endmodule
`default_nettype wire

// *** rtl/dtf_timer.v ***
// Delay timer functions: on, off, on/off and retentive on delay
`timescale 1ns/1ps
`default_nettype none
`include "dtf_consts.vh"

module dtf_timer
(
    input  wire                   mclk,         // System clock 250 MHz
    input  wire                   rst,          // Async reset, high
    input  wire [`DTF_MODE_W-1:0] mode,         // Function select
    input  wire                   tick,         // Time-base tick
    input  wire                   trigger_in,   // Trigger, from pin
    input  wire                   clear_in,     // Clear, from pin
    input  wire [`DTF_TW-1:0]     delay_time,   // Delay, on/off/ret
    input  wire [`DTF_TW-1:0]     rise_delay,   // On/off rise delay
    input  wire [`DTF_TW-1:0]     fall_delay,   // On/off fall delay
    output wire                   out,          // Timer output
    output wire [`DTF_TW-1:0]     elapsed_time  // Elapsed time
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    wire [`DTF_PIN_N-1:0] pin_raw;
    wire [`DTF_PIN_N-1:0] pin_sync;
    wire                  trg;
    wire                  rise;
    wire                  fall;
    wire                  clr;
    reg                   trg_prev_q;

    assign pin_raw[`DTF_PIN_TRG] = trigger_in;
    assign pin_raw[`DTF_PIN_CLR] = clear_in;

    // Both pins are asynchronous, so each passes two flops first
    genvar gi;
    generate
        for (gi = 0; gi < `DTF_PIN_N; gi = gi + 1)
        begin : g_sync
            reg s1_q;
            reg s2_q;

            always @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    s1_q <= 1'h0;
                    s2_q <= 1'h0;
                end
                else
                begin
                    s1_q <= pin_raw[gi];
                    s2_q <= s1_q;
                end
            end

            assign pin_sync[gi] = s2_q;
        end
    endgenerate

    // Starts low like the idle pin, so reset makes no false edge
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            trg_prev_q <= 1'h0;
        else
            trg_prev_q <= trg;
    end

    assign trg  = pin_sync[`DTF_PIN_TRG];
    assign rise = trg && !trg_prev_q;
    assign fall = !trg && trg_prev_q;
    // Clear input only exists for off delay and retentive modes
    assign clr  = pin_sync[`DTF_PIN_CLR] &&
                  ((mode == `DTF_MODE_OFF) || (mode == `DTF_MODE_RET));

    // ----------------------------------------
    // Timer control
    // ----------------------------------------
    // Counter is either parked or advancing on ticks
    localparam ST_IDLE = 1'h0;
    localparam ST_RUN  = 1'h1;

    reg                    state_q;
    reg                    state_d;
    reg                    out_q;
    reg                    out_d;
    reg                    cnt_clr;
    reg  [`DTF_TW-1:0]     target;
    wire                   done;
    wire                   run;
    reg  [`DTF_MODE_W-1:0] mode_q;
    reg                    mode_chg_q;

    // Proposals from each function, picked by the mode below
    reg                    on_state;
    reg                    on_out;
    reg                    on_clr;
    reg                    off_state;
    reg                    off_out;
    reg                    off_clr;
    reg                    oo_state;
    reg                    oo_out;
    reg                    oo_clr;
    reg                    ret_state;
    reg                    ret_out;
    reg                    ret_clr;

    assign run = (state_q == ST_RUN);

    // Mode switch restarts the function cleanly
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            mode_q     <= `DTF_MODE_ON;
            mode_chg_q <= 1'h0;
        end
        else
        begin
            mode_q     <= mode;
            mode_chg_q <= (mode != mode_q);
        end
    end

    // ----------------------------------------
    // On delay
    // ----------------------------------------
    always @*
    begin
        on_state = state_q;
        on_out   = out_q;
        on_clr   = 1'h0;
        if (!trg)
        begin
            on_state = ST_IDLE;
            on_clr   = 1'h1;                               // [R03]
            on_out   = 1'h0;                               // [R04]
        end
        else if (rise)
        begin
            on_state = ST_RUN;
            on_clr   = 1'h1;                               // [R01]
            on_out   = 1'h0;
        end
        else if (run && done)
            on_out = 1'h1;                                 // [R02]
    end

    // ----------------------------------------
    // Off delay
    // ----------------------------------------
    always @*
    begin
        off_state = state_q;
        off_out   = out_q;
        off_clr   = 1'h0;
        if (clr)
        begin
            off_state = ST_IDLE;
            off_clr   = 1'h1;                              // [R10] [R19]
            off_out   = 1'h0;
        end
        else if (trg)
        begin
            off_state = ST_IDLE;
            off_clr   = 1'h1;                              // [R09]
            off_out   = 1'h1;                              // [R06]
        end
        else if (fall)
        begin
            off_state = ST_RUN;
            off_clr   = 1'h1;                              // [R07]
        end
        else if (run && done)
        begin
            off_state = ST_IDLE;
            off_out   = 1'h0;                              // [R08]
        end
    end

    // ----------------------------------------
    // On/off delay
    // ----------------------------------------
    // Counter aims at the delay for the opposite output level
    always @*
    begin
        case (mode)
            `DTF_MODE_ONOF:
                target = out_q ? fall_delay : rise_delay;
            default:
                target = delay_time;
        endcase
    end

    always @*
    begin
        oo_state = state_q;
        oo_out   = out_q;
        oo_clr   = 1'h0;
        if (trg == out_q)
        begin
            oo_state = ST_IDLE;
            oo_clr   = 1'h1;                               // [R12] [R14]
        end
        else if (rise || fall)
        begin
            oo_state = ST_RUN;
            oo_clr   = 1'h1;                               // [R11] [R13]
        end
        else if (run && done)
        begin
            oo_state = ST_IDLE;
            oo_clr   = 1'h1;
            oo_out   = trg;                                // [R11] [R13]
        end
    end

    // ----------------------------------------
    // Retentive on delay
    // ----------------------------------------
    // Only clear or reset can stop it once started
    always @*
    begin
        ret_state = state_q;
        ret_out   = out_q;
        ret_clr   = 1'h0;
        if (clr)
        begin
            ret_state = ST_IDLE;
            ret_clr   = 1'h1;                              // [R17] [R19]
            ret_out   = 1'h0;
        end
        else if (rise && !run)
            ret_state = ST_RUN;                            // [R15] [R16]
        else if (run && done)
            ret_out = 1'h1;                                // [R15]
    end

    // ----------------------------------------
    // Function select
    // ----------------------------------------
    always @*
    begin
        // A fresh mode starts parked and low
        state_d = ST_IDLE;
        out_d   = 1'h0;
        cnt_clr = 1'h1;
        if (!mode_chg_q)
        begin
            case (mode)
                `DTF_MODE_ON:
                begin
                    state_d = on_state;
                    out_d   = on_out;
                    cnt_clr = on_clr;
                end
                `DTF_MODE_OFF:
                begin
                    state_d = off_state;
                    out_d   = off_out;
                    cnt_clr = off_clr;
                end
                `DTF_MODE_ONOF:
                begin
                    state_d = oo_state;
                    out_d   = oo_out;
                    cnt_clr = oo_clr;
                end
                `DTF_MODE_RET:
                begin
                    state_d = ret_state;
                    out_d   = ret_out;
                    cnt_clr = ret_clr;
                end
                default:
                begin
                    state_d = ST_IDLE;
                    out_d   = 1'h0;
                    cnt_clr = 1'h1;
                end
            endcase
        end
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;                            // [R05]
            out_q   <= 1'h0;
        end
        else
        begin
            state_q <= state_d;
            out_q   <= out_d;
        end
    end

    // Data output straight from its flop
    assign out = out_q;

    // ----------------------------------------
    // Elapsed time counter
    // ----------------------------------------
    dtf_counter u_cnt
    (
        .mclk    (mclk),
        .rst     (rst),
        .clr     (cnt_clr),
        .run     (run),
        .tick    (tick),
        .target  (target),
        .count_q (elapsed_time),
        .done    (done)
    );

endmodule
`default_nettype wire

// *** testbench/delay_timer_functions_bench.sv ***
// Self-checking bench for the delay timer functions
`timescale 1ns/1ps
`default_nettype none
module delay_timer_functions_bench;
    logic        mclk;
    logic        rst;
    logic [1:0]  mode;
    logic        tick;
    logic [15:0] dly;
    logic [15:0] rdl;
    logic [15:0] fdl;
    wire         trg;
    wire         clr;
    wire         q;
    wire  [15:0] el;
    integer      error_cnt;
    integer      n_checks;
    integer      seed;
    integer      d, r, f;

    dtf_prog i_prg
    (
        .mclk(mclk), .trg(trg), .clr(clr)
    );
    dtf_timer i_dut
    (
        .mclk(mclk), .rst(rst), .mode(mode), .tick(tick),
        .trigger_in(trg), .clear_in(clr), .delay_time(dly),
        .rise_delay(rdl), .fall_delay(fdl), .out(q), .elapsed_time(el)
    );

    initial
    begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [15:0] s,
                       input logic [15:0] x);
        n_checks = n_checks + 1;
        if (s !== x)
        begin
            error_cnt = error_cnt + 1;
            $display("mismatch %s exp %h seen %h", nm, x, s);
        end
    endtask

    task automatic cyc(input integer n);
        repeat (n) @(posedge mclk);
    endtask

    // Model step: pins, n ticks, then expected out and ticks (-1 open)
    task automatic st(input logic t, input logic c, input integer n,
                      input integer o, input integer e);
        i_prg.put(t, c);
        cyc(5);
        repeat (n)
        begin
            tick <= 1'h1;
            @(posedge mclk);
            tick <= 1'h0;
            @(posedge mclk);
        end
        cyc(5);
        #1;
        chk("out", {15'h0, q}, o[15:0]);
        if (e >= 0)
            chk("elapsed", el, e[15:0]);
    endtask

    task automatic md(input logic [1:0] m);
        @(posedge mclk);
        mode <= m;
        cyc(3);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        #100000;
        error_cnt = error_cnt + 1;
        tally_and_finish;
    end

    initial
    begin
        seed = 32'h4f27;
        error_cnt = 0;
        n_checks = 0;
        rst = 1'h1;
        mode = 2'h0;
        tick = 1'h0;
        d = 2 + ($random(seed) & 3);
        r = 2 + ($random(seed) & 3);
        f = 2 + ($random(seed) & 3);
        dly = d[15:0];
        rdl = r[15:0];
        fdl = f[15:0];
        cyc(5);
        rst <= 1'h0;
        st(0,0,0,0,0);
        st(1,0,d-1,0,d-1);
        st(0,0,0,0,0);
        st(1,0,d+2,1,d);
        st(0,0,0,0,0);
        md(2'h1);
        st(1,0,0,1,-1);
        st(0,0,d-1,1,d-1);
        st(1,0,0,1,-1);
        st(0,0,1,1,1);
        st(0,0,d,0,d);
        st(1,0,0,1,-1);
        st(0,0,1,1,1);
        st(0,1,0,0,0);
        st(0,0,0,0,0);
        md(2'h2);
        st(1,0,r-1,0,-1);
        st(0,0,0,0,0);
        st(1,0,r,1,-1);
        st(0,0,f-1,1,-1);
        st(1,0,0,1,-1);
        st(0,0,f,0,-1);
        md(2'h3);
        st(1,0,1,0,1);
        st(0,0,d-1,1,d);
        st(1,0,2,1,d);
        st(1,1,0,0,0);
        st(0,0,0,0,0);
        st(1,1,0,0,0);
        st(1,0,2,0,0);
        st(0,0,0,0,0);
        st(1,0,d,1,d);
        st(0,0,0,1,d);
        // Power loss after retentive expiry: nothing of the timing may survive
        @(posedge mclk);
        rst <= 1'h1;
        cyc(3);
        #1;
        chk("out", {15'h0, q}, 16'h0);
        chk("elapsed", el, 16'h0);
        @(posedge mclk);
        rst <= 1'h0;
        st(0,0,1,0,0);
        st(1,0,1,0,1);
        tally_and_finish;
    end
endmodule
`default_nettype wire

// *** testbench/dtf_chk_assertions.sv ***
// Assertion checker for the delay timer ports
`timescale 1ns/1ps
`default_nettype none
module dtf_chk
(
    input wire logic        mclk,        // Clock
    input wire logic        rst,         // Reset
    input wire logic [1:0]  mode,        // Function
    input wire logic        tick,        // Tick
    input wire logic        trigger_in,  // Trigger
    input wire logic        clear_in,    // Clear
    input wire logic [15:0] delay_time,  // Target
    input wire logic        out,         // Output
    input wire logic [15:0] elapsed_time // Elapsed
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Pins cross a two-flop sync, so four cycles cover the lag
    a_on_low_out: assert property
        ((mode == 2'h0 && !trigger_in)[*4] |=> !out)
        else $error("on delay out high");
    a_on_rise_due: assert property
        ($rose(out) && mode == 2'h0 |-> trigger_in && elapsed_time == delay_time)
        else $error("on delay out early");
    a_off_high_out: assert property
        ((mode == 2'h1 && trigger_in && !clear_in)[*4] |=> out)
        else $error("off delay out low");
    a_off_clear: assert property
        ((mode == 2'h1 && clear_in)[*4] |=> !out && elapsed_time == 16'h0)
        else $error("off delay clear ignored");
    a_ret_clear: assert property
        ((mode == 2'h3 && clear_in)[*4] |=> !out && elapsed_time == 16'h0)
        else $error("retentive clear ignored");
    a_ret_keep: assert property
        ($fell(out) && mode == 2'h3 && $past(mode) == 2'h3 |-> $past(clear_in, 2))
        else $error("retentive out lost");
    a_ret_run: assert property
        ((mode == 2'h3 && !clear_in)[*4] ##0 (tick && elapsed_time != 16'h0
        && elapsed_time < delay_time) |=> elapsed_time == $past(elapsed_time) + 16'h1)
        else $error("retentive count stalled");
    a_step_one: assert property
        (elapsed_time != $past(elapsed_time) && elapsed_time != 16'h0 |->
        $past(tick) && elapsed_time == $past(elapsed_time) + 16'h1)
        else $error("elapsed step wrong");
endmodule
bind dtf_timer dtf_chk i_chk
(
    .mclk(mclk), .rst(rst), .mode(mode), .tick(tick),
    .trigger_in(trigger_in), .clear_in(clear_in),
    .delay_time(delay_time), .out(out), .elapsed_time(elapsed_time)
);
`default_nettype wire

// *** testbench/dtf_prog.sv ***
// Program-side model driving the trigger and clear pins
`timescale 1ns/1ps
`default_nettype none
module dtf_prog
(
    input  wire logic mclk, // Clock
    output var  logic trg,  // Trigger pin
    output var  logic clr   // Clear pin
);
    initial
    begin
        trg = 1'h0;
        clr = 1'h0;
    end
    // Levels change just after an edge and hold until the next call
    task automatic put(input logic t, input logic c);
        @(posedge mclk);
        trg <= t;
        clr <= c;
    endtask
endmodule
`default_nettype wire
